// [sbt_pkg.sv]
// sbt_pkg: constants, instruction codes and state type of the boundary-scan test port
// assumes one system clock that oversamples the test clock pins
package sbt_pkg;
    localparam int IR_W = 3;
    localparam int ID_W = 32;
    localparam int BSR_LEN = 110;
    localparam int BSR_TRI_BIT = 109;
    localparam int RST_SEQ_LEN = 5;
    // instruction codes
    localparam logic [IR_W-1:0] INS_EXTEST = 3'h0;
    localparam logic [IR_W-1:0] INS_IDCODE = 3'h1;
    localparam logic [IR_W-1:0] INS_SAMPLEZ = 3'h2;
    localparam logic [IR_W-1:0] INS_SAMPLE = 3'h4;
    localparam logic [IR_W-1:0] INS_BYPASS = 3'h7;
    localparam logic [IR_W-1:0] IR_CAPTURE_VAL = 3'h1;
    // arbitrary neutral identification value, lsb set as the standard requires
    localparam logic [ID_W-1:0] ID_VALUE = 32'h0000_0001;
    localparam logic [BSR_LEN-1:0] BSR_UPD_RESET = '0;
    localparam logic PIN_PULLUP_LEVEL = 1'b1;
    localparam logic [1:0] SYNC_RESET = 2'h0;

    typedef enum logic [15:0] {
        ST_TLR = 16'h0001,
        ST_RTI = 16'h0002,
        ST_SEL_DR = 16'h0004,
        ST_CAP_DR = 16'h0008,
        ST_SH_DR = 16'h0010,
        ST_EX1_DR = 16'h0020,
        ST_PA_DR = 16'h0040,
        ST_EX2_DR = 16'h0080,
        ST_UPD_DR = 16'h0100,
        ST_SEL_IR = 16'h0200,
        ST_CAP_IR = 16'h0400,
        ST_SH_IR = 16'h0800,
        ST_EX1_IR = 16'h1000,
        ST_PA_IR = 16'h2000,
        ST_EX2_IR = 16'h4000,
        ST_UPD_IR = 16'h8000
    } sbt_state_t;
endpackage

// [sbt_bsr.sv]
// sbt_bsr: boundary scan register, shift chain plus update latches
// assumes enables are one-cycle pulses from the test port controller
`timescale 1ns/1ps
module sbt_bsr
    import sbt_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // control
    input wire logic capture_in,
    input wire logic shift_in,
    input wire logic update_in,
    input wire logic clear_in,
    // data
    input wire logic serial_in,
    input wire logic [BSR_LEN-1:0] par_in,
    output logic [BSR_LEN-1:0] chain_out,
    output logic [BSR_LEN-1:0] upd_out
);
    logic [BSR_LEN-1:0] chain_reg;
    logic [BSR_LEN-1:0] upd_reg;

    genvar i;
    generate
        for (i = 0; i < BSR_LEN; i++) begin : g_cell
            wire logic shift_src;
            // msb fed from serial in, lower cells from the one above
            if (i == BSR_LEN - 1) begin : g_top
                assign shift_src = serial_in;
            end else begin : g_mid
                assign shift_src = chain_reg[i+1];
            end
            always_ff @(posedge clk_in) begin
                if (rst_in) begin
                    chain_reg[i] <= 1'b0;
                end else if (capture_in) begin
                    chain_reg[i] <= par_in[i];
                end else if (shift_in) begin
                    chain_reg[i] <= shift_src;
                end
            end
            always_ff @(posedge clk_in) begin
                if (rst_in || clear_in) begin
                    upd_reg[i] <= BSR_UPD_RESET[i];
                end else if (update_in) begin
                    upd_reg[i] <= chain_reg[i];
                end
            end
        end
    endgenerate

    assign chain_out = chain_reg;
    assign upd_out = upd_reg;
endmodule

// [sbt_tap.sv]
// sbt_tap: boundary-scan test access port controller of the memory
// assumes test pins are asynchronous and far slower than CLK_IN; RST_IN is power-up reset
`timescale 1ns/1ps
module sbt_tap
    import sbt_pkg::*;
(
    // clock and reset
    input wire logic CLK_IN,
    input wire logic RST_IN,
    // test pins
    input wire logic TCK_IN,
    input wire logic TMS_IN,
    input wire logic TDI_IN,
    output logic TDO_OUT,
    output logic TDO_OE_OUT,
    // memory pin ring
    input wire logic [BSR_LEN-1:0] RING_IN,
    output logic [BSR_LEN-1:0] RING_DRIVE_OUT,
    output logic EXTEST_OUT,
    output logic BUS_HIGHZ_OUT
);
    logic [1:0] tck_sync_reg;
    logic tck_last_reg;
    logic [1:0] tms_sync_reg;
    logic [1:0] tdi_sync_reg;
    logic [BSR_LEN-1:0] ring_s1_reg;
    logic [BSR_LEN-1:0] ring_s2_reg;
    sbt_state_t state_reg;
    sbt_state_t state_next;
    logic [IR_W-1:0] ir_reg;
    logic [IR_W-1:0] ir_sh_reg;
    logic [ID_W-1:0] id_sh_reg;
    logic bypass_reg;
    logic tdo_reg;
    logic tdo_oe_reg;
    logic extest_reg;
    logic highz_reg;
    logic [BSR_LEN-1:0] bsr_chain;

    // pin synchronisers; mode select and data in at the pulled-up level, test clock low, while in reset
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            tck_sync_reg <= SYNC_RESET;
            tck_last_reg <= 1'b0;
            tms_sync_reg <= {2{PIN_PULLUP_LEVEL}};
            tdi_sync_reg <= {2{PIN_PULLUP_LEVEL}};
        end else begin
            tck_sync_reg <= {tck_sync_reg[0], TCK_IN};
            tck_last_reg <= tck_sync_reg[1];
            tms_sync_reg <= {tms_sync_reg[0], TMS_IN};
            tdi_sync_reg <= {tdi_sync_reg[0], TDI_IN};
        end
    end

    always_ff @(posedge CLK_IN) begin
        ring_s1_reg <= RING_IN;
        ring_s2_reg <= ring_s1_reg;
    end

    wire logic tck_rise = tck_sync_reg[1] & ~tck_last_reg;
    wire logic tck_fall = ~tck_sync_reg[1] & tck_last_reg;
    wire logic tms = tms_sync_reg[1];
    wire logic tdi = tdi_sync_reg[1];

    // controller next state
    always_comb begin
        case (state_reg)
            ST_TLR: state_next = tms ? ST_TLR : ST_RTI;
            ST_RTI: state_next = tms ? ST_SEL_DR : ST_RTI;
            ST_SEL_DR: state_next = tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: state_next = tms ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR: state_next = tms ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: state_next = tms ? ST_UPD_DR : ST_PA_DR;
            ST_PA_DR: state_next = tms ? ST_EX2_DR : ST_PA_DR;
            ST_EX2_DR: state_next = tms ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: state_next = tms ? ST_SEL_DR : ST_RTI;
            ST_SEL_IR: state_next = tms ? ST_TLR : ST_CAP_IR;
            ST_CAP_IR: state_next = tms ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR: state_next = tms ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: state_next = tms ? ST_UPD_IR : ST_PA_IR;
            ST_PA_IR: state_next = tms ? ST_EX2_IR : ST_PA_IR;
            ST_EX2_IR: state_next = tms ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: state_next = tms ? ST_SEL_DR : ST_RTI;
            default: state_next = ST_TLR;
        endcase
    end

    // state moves only on a test clock rise
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            state_reg <= ST_TLR;
        end else if (tck_rise) begin
            state_reg <= state_next;
        end
    end

    // decode of current state and instruction
    wire logic in_tlr = (state_reg == ST_TLR);
    wire logic act = tck_rise;
    wire logic cap_dr = act && (state_reg == ST_CAP_DR);
    wire logic sh_dr = act && (state_reg == ST_SH_DR);
    wire logic upd_dr = act && (state_reg == ST_UPD_DR);
    wire logic cap_ir = act && (state_reg == ST_CAP_IR);
    wire logic sh_ir = act && (state_reg == ST_SH_IR);
    wire logic upd_ir = act && (state_reg == ST_UPD_IR);
    wire logic sel_id = (ir_reg == INS_IDCODE);
    wire logic sel_bsr = (ir_reg == INS_EXTEST) || (ir_reg == INS_SAMPLE)
        || (ir_reg == INS_SAMPLEZ);
    wire logic sel_pre = (ir_reg == INS_EXTEST) || (ir_reg == INS_SAMPLE);
    wire logic in_shift = (state_reg == ST_SH_DR) || (state_reg == ST_SH_IR);
    wire logic in_ir_path = (state_reg == ST_SH_IR) || (state_reg == ST_EX1_IR)
        || (state_reg == ST_PA_IR) || (state_reg == ST_EX2_IR);
    // one register chosen, lsb toward data out; other codes fall to bypass
    wire logic dr_lsb = sel_id ? id_sh_reg[0] : (sel_bsr ? bsr_chain[0] : bypass_reg);
    wire logic path_lsb = in_ir_path ? ir_sh_reg[0] : dr_lsb;

    // instruction register
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            ir_reg <= INS_IDCODE;
            ir_sh_reg <= IR_CAPTURE_VAL;
        end else if (in_tlr) begin
            ir_reg <= INS_IDCODE;
        end else if (cap_ir) begin
            ir_sh_reg <= IR_CAPTURE_VAL;
        end else if (sh_ir) begin
            ir_sh_reg <= {tdi, ir_sh_reg[IR_W-1:1]};
        end else if (upd_ir) begin
            ir_reg <= ir_sh_reg;
        end
    end

    // identification and bypass registers
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            id_sh_reg <= ID_VALUE;
            bypass_reg <= 1'b0;
        end else begin
            if (cap_dr && sel_id) begin
                id_sh_reg <= ID_VALUE;
            end else if (sh_dr && sel_id) begin
                id_sh_reg <= {tdi, id_sh_reg[ID_W-1:1]};
            end
            if (cap_dr) begin
                bypass_reg <= 1'b0;
            end else if (sh_dr) begin
                bypass_reg <= tdi;
            end
        end
    end

    sbt_bsr u_bsr (
        .clk_in(CLK_IN),
        .rst_in(RST_IN),
        .capture_in(cap_dr && sel_bsr),
        .shift_in(sh_dr && sel_bsr),
        .update_in(upd_dr && sel_pre),
        .clear_in(in_tlr),
        .serial_in(tdi),
        .par_in(ring_s2_reg),
        .chain_out(bsr_chain),
        .upd_out(RING_DRIVE_OUT)
    );

    // data out and its enable change on test clock falls only
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            tdo_reg <= 1'b0;
            tdo_oe_reg <= 1'b0;
        end else if (tck_fall) begin
            tdo_reg <= in_shift ? path_lsb : 1'b0;
            tdo_oe_reg <= in_shift;
        end
    end

    // memory bus control follows the instruction in effect
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            extest_reg <= 1'b0;
            highz_reg <= 1'b0;
        end else begin
            extest_reg <= (ir_reg == INS_EXTEST);
            highz_reg <= (ir_reg == INS_SAMPLEZ)
                || ((ir_reg == INS_EXTEST) && !RING_DRIVE_OUT[BSR_TRI_BIT]);
        end
    end

    assign TDO_OUT = tdo_reg;
    assign TDO_OE_OUT = tdo_oe_reg;
    assign EXTEST_OUT = extest_reg;
    assign BUS_HIGHZ_OUT = highz_reg;

    // checks
    logic [2:0] tms_run_reg;
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            tms_run_reg <= 3'h0;
        end else if (tck_rise) begin
            tms_run_reg <= !tms ? 3'h0 : (tms_run_reg == 3'h7 ? 3'h7 : tms_run_reg + 3'h1);
        end
    end

    default clocking cb @(posedge CLK_IN); endclocking

    sequence s_shift_fall;
        tck_fall && in_shift;
    endsequence

    chk_state_on_rise: assert property (disable iff (RST_IN)
        $changed(state_reg) |-> $past(tck_rise)) else $error("state moved without tck rise");
    chk_tdo_on_fall: assert property (disable iff (RST_IN)
        $changed(TDO_OE_OUT) || $changed(TDO_OUT) |-> $past(tck_fall))
        else $error("tdo changed without tck fall");
    chk_oe_shift_only: assert property (disable iff (RST_IN)
        $rose(TDO_OE_OUT) |-> $past(in_shift)) else $error("tdo enabled outside shift");
    chk_tdo_lsb_out: assert property (disable iff (RST_IN)
        s_shift_fall |=> TDO_OUT == $past(path_lsb) && TDO_OE_OUT)
        else $error("tdo not lsb of path");
    chk_oe_off_reset: assert property (
        RST_IN |=> !TDO_OE_OUT) else $error("tdo driven after reset");
    chk_five_tms_reset: assert property (disable iff (RST_IN)
        tms_run_reg >= 3'h5 |-> in_tlr) else $error("five tms highs did not reset");
    chk_ir_idcode: assert property (disable iff (RST_IN)
        in_tlr |=> ir_reg == INS_IDCODE) else $error("ir not idcode in reset");
    chk_capture_ir: assert property (disable iff (RST_IN)
        cap_ir |=> ir_sh_reg[1:0] == 2'h1) else $error("capture ir pattern wrong");
    chk_bypass_clear: assert property (disable iff (RST_IN)
        cap_dr |=> !bypass_reg) else $error("bypass not cleared at capture");
    chk_ir_stable_shift: assert property (disable iff (RST_IN)
        state_reg == ST_SH_IR ##1 state_reg == ST_SH_IR |-> $stable(ir_reg))
        else $error("instruction changed while shifting");
endmodule

// [sbt_jtag_ctl.sv]
// sbt_jtag_ctl: behavioural external test controller driving the test pins
// assumes clk_in is the 250 MHz system clock; one test clock period is 40 of its cycles
`timescale 1ns/1ps
module sbt_jtag_ctl
    import sbt_pkg::*;
(
    // timing reference
    input wire logic clk_in,
    // test pins
    output logic tck_out,
    output logic tms_out,
    output logic tdi_out,
    input wire logic tdo_in
);
    logic tms_reg = 1'b1;
    logic tdi_reg = 1'b1;
    logic rel_reg = 1'b1;
    initial tck_out = 1'b0;
    // released pins read the pull-up level
    assign tms_out = rel_reg ? PIN_PULLUP_LEVEL : tms_reg;
    assign tdi_out = rel_reg ? PIN_PULLUP_LEVEL : tdi_reg;
    // one test clock period; data set at the start of the low phase, tdo sampled before the rise
    task automatic bit_op(input logic rel, input logic tms, input logic tdi, output logic tdo);
        rel_reg = rel;
        tms_reg = tms;
        tdi_reg = tdi;
        repeat (20) @(negedge clk_in);
        tdo = tdo_in;
        tck_out = 1'b1;
        repeat (20) @(negedge clk_in);
        tck_out = 1'b0;
    endtask
    // from idle to a shift state, shift n bits, stop in exit1
    task automatic scan(input logic ir, input int n, input logic [127:0] din,
            output logic [127:0] dout);
        logic d;
        dout = '0;
        bit_op(1'b0, 1'b1, 1'b1, d);
        if (ir) begin
            bit_op(1'b0, 1'b1, 1'b1, d);
        end
        bit_op(1'b0, 1'b0, 1'b1, d);
        bit_op(1'b0, 1'b0, 1'b1, d);
        for (int i = 0; i < n; i++) begin
            bit_op(1'b0, 1'(i == n - 1), din[i], d);
            dout[i] = d;
        end
    endtask
    // exit1 to update, then idle, then let outputs settle
    task automatic update_idle();
        logic d;
        bit_op(1'b0, 1'b1, 1'b1, d);
        bit_op(1'b0, 1'b0, 1'b1, d);
        repeat (8) @(negedge clk_in);
    endtask
    // five rises with released mode select
    task automatic tap_reset();
        logic d;
        repeat (5) bit_op(1'b1, 1'b0, 1'b0, d);
        repeat (8) @(negedge clk_in);
    endtask
endmodule

// [test_sbt_tap.sv]
// test_sbt_tap: self-checking bench of the boundary-scan test port
// assumes sbt_jtag_ctl drives the test pins; memory pin ring held at a fixed pattern
`timescale 1ns/1ps
module test_sbt_tap
    import sbt_pkg::*;
;
    localparam logic [BSR_LEN-1:0] RING_PAT = 110'h1234_5678_9abc_def0_1357_9bdf_0246;
    localparam logic [BSR_LEN-1:0] BSR_DIN = 110'h2000_0000_0000_0000_0000_00ab_cdef;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic tck, tms, tdi, tdo, tdo_oe, extest, highz;
    logic [BSR_LEN-1:0] ring = RING_PAT;
    logic [BSR_LEN-1:0] ring_drv;
    logic [127:0] d;
    wire tdo_w = tdo_oe ? tdo : 1'bz;
    int err_count = 0;
    int cmp_count = 0;
    always #2 clk = ~clk;

    sbt_tap u_dut (.CLK_IN(clk), .RST_IN(rst), .TCK_IN(tck), .TMS_IN(tms), .TDI_IN(tdi),
        .TDO_OUT(tdo), .TDO_OE_OUT(tdo_oe), .RING_IN(ring), .RING_DRIVE_OUT(ring_drv),
        .EXTEST_OUT(extest), .BUS_HIGHZ_OUT(highz));
    sbt_jtag_ctl u_ctl (.clk_in(clk), .tck_out(tck), .tms_out(tms), .tdi_out(tdi),
        .tdo_in(tdo_w));

    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic load(input logic [IR_W-1:0] ins);
        u_ctl.scan(1'b1, IR_W, 128'(ins), d);
        u_ctl.update_idle();
    endtask

    task automatic t_reset();
        repeat (8) @(negedge clk);
        chk(tdo_oe, 1'b0);
        chk(tdo_w, 1'bz);
        chk(extest, 1'b0);
        chk(highz, 1'b0);
        chk(ring_drv, '0);
        $display("test reset done");
    endtask
    task automatic t_ir();
        u_ctl.bit_op(1'b0, 1'b0, 1'b1, d[0]);
        u_ctl.scan(1'b1, IR_W, 128'(INS_EXTEST), d);
        chk(d[1:0], 2'h1);
        chk(extest, 1'b0);
        u_ctl.update_idle();
        chk(extest, 1'b1);
        chk(highz, 1'b1);
        chk(tdo_w, 1'bz);
        $display("test instruction done");
    endtask
    task automatic t_bypass();
        load(INS_BYPASS);
        chk(extest, 1'b0);
        u_ctl.scan(1'b0, 8, 128'h4d, d);
        chk(d[7:0], 8'h9a);
        // driver turns off a few clocks after the exit1 fall
        repeat (8) @(negedge clk);
        chk(tdo_w, 1'bz);
        u_ctl.update_idle();
        $display("test bypass done");
    endtask
    task automatic t_bsr();
        load(INS_SAMPLE);
        u_ctl.scan(1'b0, BSR_LEN, 128'(BSR_DIN), d);
        chk(d[BSR_LEN-1:0], RING_PAT);
        chk(ring_drv, '0);
        u_ctl.update_idle();
        chk(ring_drv, BSR_DIN);
        load(INS_EXTEST);
        chk(extest, 1'b1);
        chk(highz, 1'b0);
        load(INS_SAMPLEZ);
        chk(highz, 1'b1);
        chk(extest, 1'b0);
        $display("test boundary register done");
    endtask
    task automatic t_tlr_id();
        u_ctl.tap_reset();
        chk(ring_drv, '0);
        chk(highz, 1'b0);
        chk(tdo_w, 1'bz);
        u_ctl.bit_op(1'b0, 1'b0, 1'b1, d[0]);
        u_ctl.scan(1'b0, ID_W, '0, d);
        chk(d[ID_W-1:0], ID_VALUE);
        u_ctl.update_idle();
        $display("test reset and identification done");
    endtask
    task automatic t_pause();
        logic [ID_W-1:0] id_seen;
        logic b;
        id_seen = '0;
        u_ctl.bit_op(1'b0, 1'b1, 1'b1, b);
        u_ctl.bit_op(1'b0, 1'b0, 1'b1, b);
        u_ctl.bit_op(1'b0, 1'b0, 1'b1, b);
        for (int i = 0; i < ID_W; i++) begin
            u_ctl.bit_op(1'b0, 1'(i == 15 || i == ID_W - 1), 1'b1, b);
            id_seen[i] = b;
            if (i == 15) begin
                // exit1 to pause, stay, then exit2 back into shift
                u_ctl.bit_op(1'b0, 1'b0, 1'b1, b);
                u_ctl.bit_op(1'b0, 1'b0, 1'b1, b);
                chk(tdo_w, 1'bz);
                u_ctl.bit_op(1'b0, 1'b1, 1'b1, b);
                u_ctl.bit_op(1'b0, 1'b0, 1'b1, b);
            end
        end
        chk(id_seen, ID_VALUE);
        u_ctl.update_idle();
        $display("test pause in shift done");
    endtask

    initial begin
        repeat (5) @(negedge clk);
        rst = 1'b0;
        t_reset();
        t_ir();
        t_bypass();
        t_bsr();
        t_tlr_id();
        t_pause();
        test_done();
    end
    initial begin
        repeat (100000) @(posedge clk);
        err_count++;
        test_done();
    end
endmodule
